// ===== csrc_cpu_model.sv
// Processor-side model: APB master and run/stop level
`timescale 1ns/100ps
`default_nettype none
module csrc_cpu_model (
    // Clock
    input wire logic clock,
    // APB master
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Run level
    output logic cpu_run
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h00000000;
        cpu_run = 1'b0;
    end

    // ----------------------------------------
    // Bus cycle
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // No cycle limit here: a hung slave is ended by the bench timeout
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not keep the last value
        pwdata <= ~d;
    endtask

    task automatic write_parameter_record;
        logic [31:0] q;
        logic err;
        apb(1'b1, csrc_pkg::OFS_RECORD, {24'h000000, csrc_pkg::REC_PARAMS}, q, err);
    endtask

    task automatic set_run(input logic r);
        @(posedge clock);
        cpu_run <= r;
    endtask
endmodule
`default_nettype wire

// ===== csrc_out_if.sv
// Carrier between the controller and one output channel
`timescale 1ns/100ps
`default_nettype none
interface csrc_out_if;
    logic [31:0] count;
    logic [31:0] cmp;
    logic [15:0] plen;
    csrc_pkg::csrc_func_t func;
    csrc_pkg::csrc_react_t mode;
    logic subst;
    logic stopped;
    logic stop_entry;
    logic restart;
    logic level;
    modport unit (
        input count, cmp, plen, func, mode, subst, stopped, stop_entry, restart,
        output level
    );
    modport ctrl (
        output count, cmp, plen, func, mode, subst, stopped, stop_entry, restart,
        input level
    );
endinterface
`default_nettype wire

// ===== csrc_out_unit.sv
// One switched output channel with its stop reaction
`timescale 1ns/100ps
`default_nettype none
module csrc_out_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Channel carrier
    csrc_out_if.unit bus
);
    typedef struct packed {
        logic out;
        logic lvl;
        logic hold;
        logic prev_match;
        logic [15:0] pcnt;
    } csrc_unit_t;

    csrc_unit_t r;
    csrc_unit_t n;
    logic match;
    logic pend;
    logic frozen;
    logic fn;

    always_comb begin
        n = r;
        match = bus.count >= bus.cmp;
        pend = r.pcnt == csrc_pkg::PCNT_ONE;
        frozen = bus.stopped && bus.mode != csrc_pkg::RX_CONTINUE;
        n.prev_match = match;
        if (bus.restart) begin
            n.lvl = 1'b0;
            n.pcnt = '0;
        end else if (match && !r.prev_match && !frozen) begin
            n.lvl = 1'b1;
            n.pcnt = (bus.plen == '0) ? csrc_pkg::PCNT_ONE : bus.plen;
        end else if (r.pcnt != '0) begin
            n.pcnt = r.pcnt - csrc_pkg::PCNT_ONE;
            if (pend) begin
                n.lvl = 1'b0;
            end
        end
        case (bus.func)
            csrc_pkg::FN_AT_CMP: fn = match;
            csrc_pkg::FN_PULSE: fn = r.lvl;
            default: fn = 1'b0;
        endcase
        if (bus.stop_entry) begin
            n.hold = r.out && !(pend && bus.func == csrc_pkg::FN_PULSE);
        end else if (pend && bus.func == csrc_pkg::FN_PULSE) begin
            n.hold = 1'b0;
        end
        if (frozen && bus.mode == csrc_pkg::RX_SUBST) begin
            n.out = bus.subst;
        end else if (frozen) begin
            n.out = bus.stop_entry ? r.out : r.hold;
        end else begin
            n.out = fn;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.level = r.out;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_subst;
        @(posedge clock) disable iff (sys_rst)
        (bus.stopped && bus.mode == csrc_pkg::RX_SUBST) |=> (r.out == $past(bus.subst));
    endproperty
    a_subst: assert property (p_subst) else $error("substitute level not driven");

    property p_hold;
        @(posedge clock) disable iff (sys_rst)
        (bus.stopped && bus.mode == csrc_pkg::RX_HOLD && bus.func != csrc_pkg::FN_PULSE
            && $past(bus.mode) == csrc_pkg::RX_HOLD) |=> $stable(r.out);
    endproperty
    a_hold: assert property (p_hold) else $error("held output changed");

    sequence s_pulse_ends_in_hold;
        bus.stopped && bus.mode == csrc_pkg::RX_HOLD && !bus.stop_entry
            && bus.func == csrc_pkg::FN_PULSE && pend;
    endsequence
    property p_pulse_clear;
        @(posedge clock) disable iff (sys_rst)
        s_pulse_ends_in_hold ##1 (bus.stopped && bus.mode == csrc_pkg::RX_HOLD) |=> !r.out;
    endproperty
    a_pulse_clear: assert property (p_pulse_clear) else $error("pulse not cleared");

    property p_continue;
        @(posedge clock) disable iff (sys_rst)
        !frozen |=> (r.out == $past(fn));
    endproperty
    a_continue: assert property (p_continue) else $error("output not following function");
endmodule
`default_nettype wire

// ===== csrc_pkg.sv
// Shared constants and types for the stop-reaction controller
package csrc_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_STAGE = 8'h00;
    localparam logic [7:0] OFS_RECORD = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_CMP0 = 8'h0C;
    localparam logic [7:0] OFS_CMP1 = 8'h10;
    localparam logic [7:0] OFS_PLEN = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // ----------------------------------------
    // Parameter byte fields and record number
    // ----------------------------------------
    localparam int CF_REACT_LSB = 0;
    localparam int CF_SUB0_BIT = 2;
    localparam int CF_SUB1_BIT = 3;
    localparam int CF_FN0_LSB = 4;
    localparam int CF_FN1_LSB = 6;
    localparam int ST_ERR_BIT = 8;
    localparam logic [7:0] REC_PARAMS = 8'h80;
    localparam logic [7:0] RST_PARAMS = 8'h01;
    localparam logic [15:0] PCNT_ONE = 16'h0001;

    typedef enum logic [1:0] {RX_CONTINUE, RX_SUBST, RX_HOLD} csrc_react_t;
    typedef enum logic [1:0] {FN_OFF, FN_AT_CMP, FN_PULSE} csrc_func_t;
endpackage

// ===== csrc_stop_ctrl.sv
// Stop-reaction controller for a single-channel counter with two outputs
//
// Notes on behaviour
// - Continue reaction keeps counting and keeps both outputs switching while stopped.
// - Substitute reaction drives configured levels from stop until the next run.
// - Hold reaction freezes outputs at their stop-entry level until next run.
// - Under hold, a compare pulse set at stop still ends after its duration.
// - Stop-to-run under substitute or hold loads the start value, outputs resume.
// - Reaction is one parameter shared by both channels: continue, substitute or hold.
// - Processor writes parameter record 128; device accepts and applies it.
// - Reaction defaults to substitute and may change while running.
`timescale 1ns/100ps
`default_nettype none
module csrc_stop_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor state and count input
    input wire logic cpu_run,
    input wire logic count_pulse,
    // Switched outputs
    output logic switch_output_first,
    output logic switch_output_second
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic run_s1;
        logic run_s2;
        logic run_q;
        logic cnt_s1;
        logic cnt_s2;
        logic cnt_q;
        logic [31:0] count;
        logic [31:0] start;
        logic [31:0] cmp0;
        logic [31:0] cmp1;
        logic [15:0] plen;
        logic [7:0] stage;
        logic [7:0] active;
        logic rec_err;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } csrc_top_t;

    csrc_top_t r;
    csrc_top_t n;
    logic stopped;
    logic stop_entry;
    logic run_rise;
    logic restart;
    logic pulse_edge;
    logic commit;
    csrc_pkg::csrc_react_t mode;

    function automatic logic react_ok(input logic [7:0] prm);
        return prm[csrc_pkg::CF_REACT_LSB +: 2] <= 2'(csrc_pkg::RX_HOLD);
    endfunction

    function automatic csrc_pkg::csrc_func_t fn_of(input logic [7:0] prm, input int lsb);
        return csrc_pkg::csrc_func_t'(prm[lsb +: 2]);
    endfunction

    // ----------------------------------------
    // Run level and count edges
    // ----------------------------------------
    // run level synchronised, edges found
    assign stopped = !r.run_s2;
    assign stop_entry = r.run_q && !r.run_s2;
    assign run_rise = !r.run_q && r.run_s2;
    assign pulse_edge = r.cnt_s2 && !r.cnt_q;
    assign mode = csrc_pkg::csrc_react_t'(r.active[csrc_pkg::CF_REACT_LSB +: 2]);
    // startup state only for substitute and hold
    assign restart = run_rise && mode != csrc_pkg::RX_CONTINUE;
    assign commit = psel && penable && r.pready && pwrite;

    always_comb begin
        n = r;
        n.run_s1 = cpu_run;
        n.run_s2 = r.run_s1;
        n.run_q = r.run_s2;
        n.cnt_s1 = count_pulse;
        n.cnt_s2 = r.cnt_s1;
        n.cnt_q = r.cnt_s2;
        if (restart) begin
            n.count = r.start;
        end else if (pulse_edge) begin
            n.count = r.count + 32'h00000001;
        end

        // Answer one cycle into the access phase
        n.pready = psel && penable && !r.pready;
        n.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            case (paddr)
                csrc_pkg::OFS_STAGE: n.prdata = {24'h000000, r.stage};
                csrc_pkg::OFS_RECORD: n.prdata = {23'h000000, r.rec_err, r.active};
                csrc_pkg::OFS_START: n.prdata = r.start;
                csrc_pkg::OFS_CMP0: n.prdata = r.cmp0;
                csrc_pkg::OFS_CMP1: n.prdata = r.cmp1;
                csrc_pkg::OFS_PLEN: n.prdata = {16'h0000, r.plen};
                csrc_pkg::OFS_COUNT: n.prdata = r.count;
                csrc_pkg::OFS_STATUS: n.prdata = {29'h00000000, switch_output_second,
                    switch_output_first, stopped};
                default: begin
                    n.prdata = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        if (commit) begin
            case (paddr)
                csrc_pkg::OFS_STAGE: n.stage = pwdata[7:0];
                // only record 128 with a valid reaction applies
                // applies in run or stop alike
                csrc_pkg::OFS_RECORD: begin
                    if (pwdata[7:0] == csrc_pkg::REC_PARAMS && react_ok(r.stage)) begin
                        n.active = r.stage;
                        n.rec_err = 1'b0;
                    end else begin
                        n.rec_err = 1'b1;
                    end
                end
                csrc_pkg::OFS_START: n.start = pwdata;
                csrc_pkg::OFS_CMP0: n.cmp0 = pwdata;
                csrc_pkg::OFS_CMP1: n.cmp1 = pwdata;
                csrc_pkg::OFS_PLEN: n.plen = pwdata[15:0];
                default: n.rec_err = r.rec_err;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
            r.stage <= csrc_pkg::RST_PARAMS;
            r.active <= csrc_pkg::RST_PARAMS;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;

    // ----------------------------------------
    // Output channels
    // ----------------------------------------
    csrc_out_if ch0 ();
    csrc_out_if ch1 ();

    assign ch0.count = r.count;
    assign ch0.cmp = r.cmp0;
    assign ch0.plen = r.plen;
    assign ch0.func = fn_of(r.active, csrc_pkg::CF_FN0_LSB);
    assign ch0.mode = mode;
    assign ch0.subst = r.active[csrc_pkg::CF_SUB0_BIT];
    assign ch0.stopped = stopped;
    assign ch0.stop_entry = stop_entry;
    assign ch0.restart = restart;

    assign ch1.count = r.count;
    assign ch1.cmp = r.cmp1;
    assign ch1.plen = r.plen;
    assign ch1.func = fn_of(r.active, csrc_pkg::CF_FN1_LSB);
    assign ch1.mode = mode;
    assign ch1.subst = r.active[csrc_pkg::CF_SUB1_BIT];
    assign ch1.stopped = stopped;
    assign ch1.stop_entry = stop_entry;
    assign ch1.restart = restart;

    csrc_out_unit u_out0 (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus(ch0.unit)
    );

    csrc_out_unit u_out1 (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus(ch1.unit)
    );

    // Both come from the channel flip-flops
    assign switch_output_first = ch0.level;
    assign switch_output_second = ch1.level;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_restart;
        @(posedge clock) disable iff (sys_rst)
        (run_rise && mode != csrc_pkg::RX_CONTINUE) |=> (r.count == $past(r.start));
    endproperty
    a_restart: assert property (p_restart) else $error("start value not loaded");

    property p_counting;
        @(posedge clock) disable iff (sys_rst)
        (pulse_edge && !restart) |=> (r.count == $past(r.count) + 32'h00000001);
    endproperty
    a_counting: assert property (p_counting) else $error("pulse not counted");

    sequence s_record_write;
        psel && penable && pwrite && r.pready && paddr == csrc_pkg::OFS_RECORD
            && pwdata[7:0] == csrc_pkg::REC_PARAMS && react_ok(r.stage);
    endsequence
    property p_record;
        @(posedge clock) disable iff (sys_rst)
        s_record_write |=> (r.active == $past(r.stage)) && !r.rec_err;
    endproperty
    a_record: assert property (p_record) else $error("record not applied");

    property p_default;
        @(posedge clock)
        $past(sys_rst) && !sys_rst |-> mode == csrc_pkg::RX_SUBST;
    endproperty
    a_default: assert property (p_default) else $error("reaction not substitute after reset");

    property p_mode_sel;
        @(posedge clock) disable iff (sys_rst)
        react_ok(r.active);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("invalid reaction active");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the stop-reaction controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock;
    logic sys_rst;
    logic count_pulse;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_run;
    logic switch_output_first;
    logic switch_output_second;
    logic [31:0] q;
    logic err;
    int n_fail;
    int n_checks;
    int cycles;
    int seed;
    int cnt;
    int start;
    int base;
    int r;
    logic [31:0] held;

    csrc_stop_ctrl csrc_stop_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_run(cpu_run), .count_pulse(count_pulse),
        .switch_output_first(switch_output_first),
        .switch_output_second(switch_output_second));
    csrc_cpu_model csrc_cpu_model_inst (.clock(clock), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_run(cpu_run));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        csrc_cpu_model_inst.apb(1'b1, a, d, q, err);
    endtask

    task automatic rd(input logic [7:0] a);
        csrc_cpu_model_inst.apb(1'b0, a, 32'h00000000, q, err);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            count_pulse <= 1'b1;
            repeat (3) @(posedge clock);
            count_pulse <= 1'b0;
            repeat (3) @(posedge clock);
            cnt++;
        end
        repeat (6) @(posedge clock);
    endtask

    function automatic logic [31:0] eo(input int c, input int b);
        return {30'h0, c >= b + 2, c >= b + 5};
    endfunction

    task automatic wrap_up;
        $display("Counts: %0d checks, %0d mismatches", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        count_pulse = 1'b0;
        n_fail = 0;
        n_checks = 0;
        cycles = 0;
        seed = 32'hBBDC0084;
        for (r = 0; r < 3; r++) begin
            sys_rst <= 1'b1;
            csrc_cpu_model_inst.set_run(1'b0);
            repeat (1) @(posedge clock);
            sys_rst <= 1'b0;
            rd(csrc_pkg::OFS_STAGE);
            chk(q, 32'h00000001); // default substitute
            if (r == 0) begin
                rd(8'h20);
                chk({31'h0, err}, 32'h00000001); // unmapped refused
                wr(csrc_pkg::OFS_STAGE, 32'h00000002);
                wr(csrc_pkg::OFS_RECORD, 32'h0000007F);
                rd(csrc_pkg::OFS_RECORD);
                chk(q, 32'h00000101); // wrong record not applied
            end
            start = $random(seed) & 32'h00000FFF;
            base = (r != 0) ? start : 0;
            wr(csrc_pkg::OFS_START, start);
            wr(csrc_pkg::OFS_CMP0, base + 5);
            wr(csrc_pkg::OFS_CMP1, base + 2);
            wr(csrc_pkg::OFS_PLEN, 32'h00000028);
            wr(csrc_pkg::OFS_STAGE, 32'h00000054 | r);
            csrc_cpu_model_inst.write_parameter_record();
            rd(csrc_pkg::OFS_RECORD);
            chk({24'h0, q[7:0]}, 32'h00000054 | r); // applied
            csrc_cpu_model_inst.set_run(1'b1);
            repeat (8) @(posedge clock);
            cnt = base;
            pulses(3);
            held = eo(cnt, base);
            chk({30'h0, switch_output_second, switch_output_first}, held);
            csrc_cpu_model_inst.set_run(1'b0);
            repeat (8) @(posedge clock);
            pulses(4);
            if (r == 1) begin
                held = 32'h00000001;
            end else if (r == 0) begin
                held = eo(cnt, base);
            end
            chk({30'h0, switch_output_second, switch_output_first}, held);
            rd(csrc_pkg::OFS_STATUS);
            chk(q, {29'h0, held[1:0], 1'b1});
            rd(csrc_pkg::OFS_COUNT);
            chk(q, cnt); // counting goes on
            csrc_cpu_model_inst.set_run(1'b1);
            repeat (8) @(posedge clock);
            if (r != 0) begin
                cnt = start;
            end
            rd(csrc_pkg::OFS_COUNT);
            chk(q, cnt); // start value loaded under substitute and hold, count kept under continue
            chk({30'h0, switch_output_second, switch_output_first}, eo(cnt, base));
            if (r == 2) begin
                // Pulse function on the second output, frozen mid-pulse
                wr(csrc_pkg::OFS_CMP1, cnt + 1);
                wr(csrc_pkg::OFS_STAGE, 32'h00000096);
                csrc_cpu_model_inst.write_parameter_record();
                pulses(1);
                csrc_cpu_model_inst.set_run(1'b0);
                repeat (8) @(posedge clock);
                chk({30'h0, switch_output_second, switch_output_first}, 32'h2);
                repeat (40) @(posedge clock);
                chk({30'h0, switch_output_second, switch_output_first}, 32'h0);
            end
            $display("Reaction %0d test done", r);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
